/* File: shared/hmi_pkg.sv */
package hmi_pkg;

  // ----------------------------------------------------------------
  // control cycle
  // ----------------------------------------------------------------
  localparam int unsigned CYCLE_CLKS = 16;
  localparam int unsigned CNT_W = $clog2(CYCLE_CLKS);

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PROG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_SEL_ACK = 8'h08;
  localparam logic [7:0] ADDR_CMD_ACK = 8'h0c;
  localparam logic [7:0] ADDR_KEY = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_PROT = 8'h1c;
  localparam logic [7:0] ADDR_LIST_IDX = 8'h20;
  localparam logic [7:0] ADDR_LIST_ENT = 8'h24;

  // ----------------------------------------------------------------
  // fields, codes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned KEY_LOCK_BIT = 2;
  localparam logic [7:0] NO_PROGRAM = 8'h00;
  localparam logic [7:0] USER_MAX = 8'h64;
  localparam logic [7:0] BUILDER_MAX = 8'hc8;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_STORE = 8'h01;
  localparam logic [7:0] CMD_RESELECT = 8'h02;
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_BUILDER = 2'h1;
  localparam logic [1:0] LVL_VENDOR = 2'h2;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] PROT_RESET = LVL_USER;

  typedef enum logic [0:0] {
    JOB_IDLE = 1'b0,
    JOB_BUSY = 1'b1
  } job_state_t;

  // bit 0 done, bit 1 error, as seen in the acknowledge bytes
  typedef struct packed {
    logic err;
    logic done;
  } ack_t;

  // protection level that a program number demands
  function automatic logic [1:0] class_of(input logic [7:0] n);
    if (n <= USER_MAX)
      return LVL_USER;
    else if (n <= BUILDER_MAX)
      return LVL_BUILDER;
    else
      return LVL_VENDOR;
  endfunction

endpackage

/* File: logic/ctrl_tick.sv */
`timescale 1ns/1ps
// one-cycle pulse at the start of every control cycle
module ctrl_tick (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic tick_o
);

  logic [hmi_pkg::CNT_W-1:0] cnt;
  logic [hmi_pkg::CNT_W-1:0] next_cnt;
  logic next_tick;

  always_comb
  begin
    next_tick = (cnt == hmi_pkg::CNT_W'(hmi_pkg::CYCLE_CLKS - 1));
    next_cnt = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule

/* File: logic/ack_hold.sv */
`timescale 1ns/1ps
// holds an acknowledge for one control cycle, then drops it
module ack_hold (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,
  input hmi_pkg::ack_t result_i,
  output hmi_pkg::ack_t ack_o
);

  hmi_pkg::ack_t next_ack;

  always_comb
  begin
    next_ack = ack_o;
    if (tick_i)
      next_ack = '0;
    if (|result_i)
      next_ack = result_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_o <= '0;
    else
      ack_o <= next_ack;
  end

  ack_rise_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(|ack_o) |-> $past(tick_i))
    else $error("acknowledge rose off the control tick");

  ack_fall_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(|ack_o) |-> $past(tick_i))
    else $error("acknowledge dropped off the control tick");

endmodule

/* File: logic/hmi_program_select_handshake.sv */
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - nonzero number seen: start job, clear byte
// - program numbers run from 1 to 255
// - classes: 1-100 user, 101-200 builder, rest vendor
// - acknowledge flags last one control cycle
// - done flag when selection succeeds
// - error flag when selection fails
// - command 0 none, 1 store, 2 reselect
// - nonzero command seen: start job, clear byte
// - command done flag on success
// - command error flag on failure
// - keyboard lock bit 2 disables keyboard
module hmi_program_select_handshake (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic keyboard_lock_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic tick, setup, wr, rd;
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pready_o & pwrite_i;
  assign rd = psel_i & penable_i & pready_o & ~pwrite_i;

  function automatic logic wr_hit(input logic [7:0] a);
    return wr && (paddr_i == a);
  endfunction

  // number is mapped, allowed at this level and in range
  function automatic logic prog_ok(input logic [7:0] n,
                                   input logic mapped,
                                   input logic [1:0] lvl);
    return (n != hmi_pkg::NO_PROGRAM) && mapped &&
           (hmi_pkg::class_of(n) <= lvl);
  endfunction

  ctrl_tick u_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hmi_pkg::job_state_t sel_state, next_sel_state;
  hmi_pkg::job_state_t cmd_state, next_cmd_state;
  logic [7:0] prog_num, next_prog_num, sel_job, next_sel_job;
  logic [7:0] cmd_code, next_cmd_code, cmd_job, next_cmd_job;
  logic [7:0] current_prog, next_current, stored_prog, next_stored;
  logic [7:0] key_ctrl, next_key, list_idx, next_idx;
  logic [3:0] mask, next_mask, status, next_status;
  logic [1:0] prot_lvl, next_prot;
  logic [255:0] list_valid, next_list_valid;
  logic [31:0] next_rdata;
  logic next_ready, next_err, next_irq, cmd_ok;
  hmi_pkg::ack_t sel_res, cmd_res, sel_ack, cmd_ack;
  hmi_pkg::ack_t res_arr [2];
  hmi_pkg::ack_t ack_arr [2];

  // ----------------------------------------------------------------
  // program selection job
  // ----------------------------------------------------------------
  always_comb
  begin
    next_sel_state = sel_state;
    next_sel_job = sel_job;
    next_prog_num = prog_num;
    sel_res = '0;
    if (tick)
    begin
      case (sel_state)
        hmi_pkg::JOB_IDLE:
          if (prog_num != hmi_pkg::NO_PROGRAM)
          begin
            next_sel_job = prog_num;
            next_prog_num = hmi_pkg::NO_PROGRAM;
            next_sel_state = hmi_pkg::JOB_BUSY;
          end
        hmi_pkg::JOB_BUSY:
        begin
          sel_res.done = prog_ok(sel_job, list_valid[sel_job],
                                 prot_lvl);
          sel_res.err = ~sel_res.done;
          next_sel_state = hmi_pkg::JOB_IDLE;
        end
        default: next_sel_state = hmi_pkg::JOB_IDLE;
      endcase
    end
    // a new request written in the pick-up cycle is kept
    if (wr_hit(hmi_pkg::ADDR_PROG))
      next_prog_num = pwdata_i[7:0];
  end

  // ----------------------------------------------------------------
  // command job and program memory
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cmd_state = cmd_state;
    next_cmd_job = cmd_job;
    next_cmd_code = cmd_code;
    next_current = current_prog;
    next_stored = stored_prog;
    cmd_res = '0;
    case (cmd_job)
      hmi_pkg::CMD_STORE: cmd_ok = current_prog != hmi_pkg::NO_PROGRAM;
      hmi_pkg::CMD_RESELECT:
        cmd_ok = prog_ok(stored_prog, list_valid[stored_prog], prot_lvl);
      default: cmd_ok = 1'b0;
    endcase
    if (tick)
    begin
      case (cmd_state)
        hmi_pkg::JOB_IDLE:
          if (cmd_code != hmi_pkg::CMD_NONE)
          begin
            next_cmd_job = cmd_code;
            next_cmd_code = hmi_pkg::CMD_NONE;
            next_cmd_state = hmi_pkg::JOB_BUSY;
          end
        hmi_pkg::JOB_BUSY:
        begin
          cmd_res.done = cmd_ok;
          cmd_res.err = ~cmd_ok;
          next_cmd_state = hmi_pkg::JOB_IDLE;
        end
        default: next_cmd_state = hmi_pkg::JOB_IDLE;
      endcase
    end
    if (wr_hit(hmi_pkg::ADDR_CMD))
      next_cmd_code = pwdata_i[7:0];
    if (cmd_res.done && cmd_job == hmi_pkg::CMD_STORE)
      next_stored = current_prog;
    if (cmd_res.done && cmd_job == hmi_pkg::CMD_RESELECT)
      next_current = stored_prog;
    // a selection finishing in the same tick has the last word
    if (sel_res.done)
      next_current = sel_job;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_state <= hmi_pkg::JOB_IDLE;
      cmd_state <= hmi_pkg::JOB_IDLE;
      prog_num <= hmi_pkg::NO_PROGRAM;
      cmd_code <= hmi_pkg::CMD_NONE;
      sel_job <= hmi_pkg::NO_PROGRAM;
      cmd_job <= hmi_pkg::CMD_NONE;
      current_prog <= hmi_pkg::NO_PROGRAM;
      stored_prog <= hmi_pkg::NO_PROGRAM;
    end
    else
    begin
      sel_state <= next_sel_state;
      cmd_state <= next_cmd_state;
      prog_num <= next_prog_num;
      cmd_code <= next_cmd_code;
      sel_job <= next_sel_job;
      cmd_job <= next_cmd_job;
      current_prog <= next_current;
      stored_prog <= next_stored;
    end
  end

  // ----------------------------------------------------------------
  // acknowledge holding
  // ----------------------------------------------------------------
  assign res_arr[0] = sel_res;
  assign res_arr[1] = cmd_res;
  assign sel_ack = ack_arr[0];
  assign cmd_ack = ack_arr[1];

  for (genvar g = 0; g < 2; g++)
  begin : g_ack
    ack_hold u_ack (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick),
      .result_i(res_arr[g]),
      .ack_o(ack_arr[g])
    );
  end

  // ----------------------------------------------------------------
  // configuration, interrupt and bus answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_key = key_ctrl;
    next_mask = mask;
    next_prot = prot_lvl;
    next_idx = list_idx;
    next_list_valid = list_valid;
    next_status = status;
    if (wr_hit(hmi_pkg::ADDR_KEY))
      next_key = pwdata_i[7:0];
    if (wr_hit(hmi_pkg::ADDR_IRQ_MASK))
      next_mask = pwdata_i[3:0];
    if (wr_hit(hmi_pkg::ADDR_PROT))
      next_prot = pwdata_i[1:0];
    if (wr_hit(hmi_pkg::ADDR_LIST_IDX))
      next_idx = pwdata_i[7:0];
    if (wr_hit(hmi_pkg::ADDR_LIST_ENT))
      next_list_valid[list_idx] = pwdata_i[0];
    if (rd && paddr_i == hmi_pkg::ADDR_IRQ_STAT)
      next_status = '0;
    // an event in the clearing read's cycle survives it
    next_status = next_status | {cmd_res, sel_res};
    next_irq = |(next_status & next_mask);
    next_ready = setup;
    next_err = 1'b0;
    next_rdata = '0;
    if (setup)
    begin
      case (paddr_i)
        hmi_pkg::ADDR_PROG: next_rdata[7:0] = prog_num;
        hmi_pkg::ADDR_CMD: next_rdata[7:0] = cmd_code;
        hmi_pkg::ADDR_SEL_ACK: next_rdata[1:0] = sel_ack;
        hmi_pkg::ADDR_CMD_ACK: next_rdata[1:0] = cmd_ack;
        hmi_pkg::ADDR_KEY: next_rdata[7:0] = key_ctrl;
        hmi_pkg::ADDR_IRQ_STAT: next_rdata[3:0] = status;
        hmi_pkg::ADDR_IRQ_MASK: next_rdata[3:0] = mask;
        hmi_pkg::ADDR_PROT: next_rdata[1:0] = prot_lvl;
        hmi_pkg::ADDR_LIST_IDX: next_rdata[7:0] = list_idx;
        hmi_pkg::ADDR_LIST_ENT: next_rdata[0] = list_valid[list_idx];
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      key_ctrl <= hmi_pkg::KEY_RESET;
      mask <= hmi_pkg::MASK_RESET;
      prot_lvl <= hmi_pkg::PROT_RESET;
      list_idx <= '0;
      list_valid <= '0;
      status <= '0;
      irq_o <= 1'b0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else
    begin
      key_ctrl <= next_key;
      mask <= next_mask;
      prot_lvl <= next_prot;
      list_idx <= next_idx;
      list_valid <= next_list_valid;
      status <= next_status;
      irq_o <= next_irq;
      pready_o <= next_ready;
      pslverr_o <= next_err;
      prdata_o <= next_rdata;
    end
  end

  assign keyboard_lock_o = key_ctrl[hmi_pkg::KEY_LOCK_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sel_pickup_a: assert property (tick && sel_state == hmi_pkg::JOB_IDLE
    && prog_num != 8'h00 && !wr_hit(hmi_pkg::ADDR_PROG) |=>
    prog_num == 8'h00 && sel_state == hmi_pkg::JOB_BUSY)
    else $error("selection byte not cleared on pick-up");

  sel_range_a: assert property (sel_state == hmi_pkg::JOB_BUSY |->
    sel_job != 8'h00)
    else $error("selection job with number zero");

  sel_class_a: assert property (sel_res.done |->
    hmi_pkg::class_of(sel_job) <= prot_lvl)
    else $error("selection above protection level");

  sel_done_a: assert property (sel_res.done |=>
    sel_ack.done && current_prog == $past(sel_job))
    else $error("selection success not shown");

  sel_err_a: assert property (tick && sel_state == hmi_pkg::JOB_BUSY
    && !list_valid[sel_job] |=> sel_ack.err && !sel_ack.done)
    else $error("unmapped selection not refused");

  ack_life_a: assert property ($rose(sel_ack.done) |->
    sel_ack.done [*8] ##1 sel_ack.done [*8] ##1 !sel_ack.done)
    else $error("selection acknowledge not one control cycle");

  cmd_pickup_a: assert property (tick && cmd_state == hmi_pkg::JOB_IDLE
    && cmd_code != 8'h00 && !wr_hit(hmi_pkg::ADDR_CMD) |=>
    cmd_code == 8'h00 ##[1:16] cmd_ack != '0)
    else $error("command not picked up and answered");

  cmd_store_a: assert property (cmd_res.done && cmd_job == 8'h01 |=>
    stored_prog == $past(current_prog))
    else $error("store command did not keep name");

  cmd_done_a: assert property (cmd_res.done |=> cmd_ack.done)
    else $error("command success not shown");

  cmd_err_a: assert property (tick && cmd_state == hmi_pkg::JOB_BUSY
    && cmd_job > 8'h02 |=> cmd_ack.err)
    else $error("unknown command not refused");

  key_lock_a: assert property (wr_hit(hmi_pkg::ADDR_KEY) |=>
    keyboard_lock_o == $past(pwdata_i[2]))
    else $error("keyboard lock not following write");

  sel_ok_c: cover property (sel_ack.done);
  sel_fail_c: cover property (sel_ack.err);
  reselect_c: cover property (cmd_res.done && cmd_job == 8'h02);
  irq_c: cover property ($rose(irq_o));

endmodule

/* File: sim/apb_requester.sv */
`timescale 1ns/1ps
// --------
// requester side of the panel mailbox, an apb master
// --------
module apb_requester (
  input wire logic clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // psel stays up so that transfers can chain without an idle cycle
  // no wait limit here: only the bench watchdog ends a stuck transfer
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    penable_o <= 1'b0;
  endtask

  task automatic rel();
    psel_o <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
    rel();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q,
    output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
    rel();
  endtask

  // reads every second clock, so a flag held 16 clocks is seen 8 times
  task automatic job(input logic [7:0] req_a, input logic [7:0] code,
    input logic [7:0] ack_a, output logic [31:0] b, output logic [31:0] ack,
    output int held);
    logic e;
    logic [31:0] q;
    int n;
    wr(req_a, {24'h00_0000, code});
    n = 0;
    do
    begin
      rd(req_a, b, e);
      n++;
    end
    while (b !== 32'h0000_0000 && n < 20);
    n = 0;
    do
    begin
      xfer(1'b0, ack_a, 32'h0000_0000, ack, e);
      n++;
    end
    while (ack === 32'h0000_0000 && n < 40);
    held = 0;
    q = ack;
    while (q !== 32'h0000_0000 && held < 20)
    begin
      held++;
      xfer(1'b0, ack_a, 32'h0000_0000, q, e);
    end
    rel();
  endtask
endmodule

/* File: sim/hmi_program_select_handshake_bench.sv */
`timescale 1ns/1ps
module hmi_program_select_handshake_bench;
  logic clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, irq, lock;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] ra [8] = '{hmi_pkg::ADDR_PROG, hmi_pkg::ADDR_CMD,
    hmi_pkg::ADDR_SEL_ACK, hmi_pkg::ADDR_CMD_ACK, hmi_pkg::ADDR_KEY,
    hmi_pkg::ADDR_IRQ_STAT, hmi_pkg::ADDR_IRQ_MASK, hmi_pkg::ADDR_PROT};
  logic [7:0] nums [5] = '{8'h64, 8'h65, 8'hc8, 8'hc9, 8'hff};
  logic [1:0] lv [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic [1:0] ok [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1};

  hmi_program_select_handshake u_hmi_program_select_handshake (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq), .keyboard_lock_o(lock));

  apb_requester u_apb_requester (
    .clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // level outputs are looked at once the edge's updates have landed
  task automatic pin(input logic v, input logic exp);
    @(negedge clk_i);
    check({31'h0, v}, {31'h0, exp});
    @(posedge clk_i);
  endtask

  task automatic run(input logic [7:0] req_a, input logic [7:0] ack_a,
    input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] b, a;
    int h;
    u_apb_requester.job(req_a, code, ack_a, b, a, h);
    check(b, 32'h0000_0000);
    check(a, exp);
    check(32'(h), 32'h0000_0008);
  endtask

  task automatic map(input logic [7:0] n);
    u_apb_requester.wr(hmi_pkg::ADDR_LIST_IDX, {24'h00_0000, n});
    u_apb_requester.wr(hmi_pkg::ADDR_LIST_ENT, 32'h0000_0001);
  endtask

  initial
  begin
    logic [31:0] q;
    logic e;
    rst_b_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    u_apb_requester.wr(hmi_pkg::ADDR_SEL_ACK, 32'h0000_0003);
    foreach (ra[i])
    begin
      u_apb_requester.rd(ra[i], q, e);
      check(q, 32'h0000_0000);
      check({31'h0, e}, 32'h0000_0000);
    end
    u_apb_requester.rd(8'h40, q, e);
    check(q, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
    u_apb_requester.wr(hmi_pkg::ADDR_KEY, 32'h0000_0004);
    pin(lock, 1'b1);
    u_apb_requester.wr(hmi_pkg::ADDR_KEY, 32'h0000_0000);
    pin(lock, 1'b0);
    // store before any selection has nothing to store
    run(hmi_pkg::ADDR_CMD, hmi_pkg::ADDR_CMD_ACK, 8'h01, 32'h2);
    pin(irq, 1'b0);
    u_apb_requester.rd(hmi_pkg::ADDR_IRQ_STAT, q, e);
    check(q, 32'h0000_0008);
    u_apb_requester.wr(hmi_pkg::ADDR_IRQ_MASK, 32'h0000_000f);
    map(8'h05);
    run(hmi_pkg::ADDR_PROG, hmi_pkg::ADDR_SEL_ACK, 8'h05, 32'h1);
    pin(irq, 1'b1);
    u_apb_requester.rd(hmi_pkg::ADDR_IRQ_STAT, q, e);
    check(q, 32'h0000_0001);
    pin(irq, 1'b0);
    u_apb_requester.wr(hmi_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    run(hmi_pkg::ADDR_PROG, hmi_pkg::ADDR_SEL_ACK, 8'h06, 32'h2);
    pin(irq, 1'b0);
    u_apb_requester.rd(hmi_pkg::ADDR_IRQ_STAT, q, e);
    check(q, 32'h0000_0002);
    // class boundaries against the protection level
    foreach (nums[i])
    begin
      map(nums[i]);
      u_apb_requester.wr(hmi_pkg::ADDR_PROT, {30'h0, lv[i]});
      run(hmi_pkg::ADDR_PROG, hmi_pkg::ADDR_SEL_ACK, nums[i],
        {30'h0, ok[i]});
    end
    run(hmi_pkg::ADDR_CMD, hmi_pkg::ADDR_CMD_ACK, 8'h01, 32'h1);
    run(hmi_pkg::ADDR_CMD, hmi_pkg::ADDR_CMD_ACK, 8'h02, 32'h1);
    run(hmi_pkg::ADDR_CMD, hmi_pkg::ADDR_CMD_ACK, 8'h03, 32'h2);
    u_apb_requester.wr(hmi_pkg::ADDR_PROT, 32'h0000_0000);
    run(hmi_pkg::ADDR_CMD, hmi_pkg::ADDR_CMD_ACK, 8'h02, 32'h2);
    u_apb_requester.wr(hmi_pkg::ADDR_CMD, 32'h0000_0000);
    repeat (40) @(posedge clk_i);
    u_apb_requester.rd(hmi_pkg::ADDR_CMD_ACK, q, e);
    check(q, 32'h0000_0000);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    results();
  end
endmodule
